// ==== logic/pmic_power_ctl.sv ====
`timescale 1ns/10ps
`default_nettype none

module pmic_power_ctl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // special-function register access
  input wire pmic_pkg::pmic_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // interrupt sources
  input wire logic ext_irq_zero_i,
  input wire logic ext_irq_one_i,
  input wire logic ext_irq_zero_enable_i,
  input wire logic ext_irq_one_enable_i,
  input wire logic irq_pending_i,
  // counter1 input pin
  input wire logic counter1_input_pin_i,
  // serial receiver status
  input wire pmic_pkg::pmic_rx_err_t rx_err_i,
  input wire logic rx_char_done_i,
  input wire logic rx_stop_bit_i,
  input wire logic rx_buf_unread_i,
  // power and port control
  output logic cpu_clk_stop_o,
  output logic periph_clk_stop_o,
  output logic osc_stop_o,
  output logic [1:0] port_one_drive_o,
  output logic [1:0] port_two_drive_o,
  output logic [1:0] port_three_drive_o,
  output logic watchdog_bit_o,
  output logic timer_width_bit_o,
  output logic baud_doubler_o
);

  logic [7:0] power_control_reg;
  logic [7:0] port_io_control_reg;
  pmic_pkg::pmic_state_t state_reg;
  pmic_pkg::pmic_state_t state_next;
  logic pin_down_reg;
  logic pin_last_reg;
  logic [1:0] drive_one_reg;
  logic [1:0] drive_two_reg;
  logic [1:0] drive_three_reg;

  logic wr_pc;
  logic wr_io;
  logic pin_fall;
  logic pin_rise;
  logic ext_wake;
  logic any_wake;
  logic overrun_evt;
  logic framing_evt;
  logic fault_evt;
  logic in_power_down;

  // drive mode of one port: floating wins over high impedance
  function automatic logic [1:0] port_mode(input logic float_sel, input logic hz_sel,
                                           input logic shut_float);
    if (float_sel || shut_float) begin
      port_mode = pmic_pkg::PMIC_DRIVE_FLOAT;
    end else if (hz_sel) begin
      port_mode = pmic_pkg::PMIC_DRIVE_HIGH_Z;
    end else begin
      port_mode = pmic_pkg::PMIC_DRIVE_NORMAL;
    end
  endfunction

  assign wr_pc = sfr_req_i.wr && (sfr_req_i.addr == pmic_pkg::ADDR_POWER_CONTROL);
  assign wr_io = sfr_req_i.wr && (sfr_req_i.addr == pmic_pkg::ADDR_PORT_IO_CONTROL);
  assign pin_fall = pin_last_reg && !counter1_input_pin_i;
  assign pin_rise = !pin_last_reg && counter1_input_pin_i;

  // external wake gated by enables unless the wake policy lets any request through
  assign ext_wake = (ext_irq_zero_i && ext_irq_zero_enable_i) ||
                    (ext_irq_one_i && ext_irq_one_enable_i);
  assign any_wake = power_control_reg[pmic_pkg::PC_WAKE_POLICY] ?
                    (irq_pending_i || ext_irq_zero_i || ext_irq_one_i) : ext_wake;

  // the receiver may flag errors directly or through its character status
  assign overrun_evt = rx_err_i.overrun || (rx_char_done_i && rx_buf_unread_i);
  assign framing_evt = rx_err_i.framing || (rx_char_done_i && !rx_stop_bit_i);
  assign fault_evt = overrun_evt || framing_evt;

  assign in_power_down = (state_reg == pmic_pkg::PMIC_SW_DOWN) || pin_down_reg;

  // software state machine; the pin path lives in its own flop
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pmic_pkg::PMIC_RUN: begin
        if (wr_pc && sfr_req_i.wdata[pmic_pkg::PC_POWER_DOWN]) begin
          // pending request with wake policy: power-down never takes hold
          if (!(sfr_req_i.wdata[pmic_pkg::PC_WAKE_POLICY] && irq_pending_i)) begin
            state_next = pmic_pkg::PMIC_SW_DOWN;
          end
        end else if (wr_pc && sfr_req_i.wdata[pmic_pkg::PC_DOZE_REQUEST]) begin
          if (!irq_pending_i) begin
            state_next = pmic_pkg::PMIC_IDLE;
          end
        end
      end
      pmic_pkg::PMIC_IDLE: begin
        // idle ends on any request; the policy only widens external wake
        if (irq_pending_i || any_wake) begin
          state_next = pmic_pkg::PMIC_RUN;
        end
      end
      pmic_pkg::PMIC_SW_DOWN: begin
        if (any_wake) begin
          state_next = pmic_pkg::PMIC_RUN;
        end
      end
      pmic_pkg::PMIC_HW_DOWN: begin
        state_next = pmic_pkg::PMIC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= pmic_pkg::PMIC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // pin-driven power-down, independent of the software path
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_last_reg <= 1'b1;
      pin_down_reg <= 1'b0;
    end else begin
      pin_last_reg <= counter1_input_pin_i;
      if (pin_down_reg && pin_rise) begin
        pin_down_reg <= 1'b0;
      end else if (pin_fall && power_control_reg[pmic_pkg::PC_PIN_SHUTDOWN_ENABLE]) begin
        pin_down_reg <= 1'b1;
      end
    end
  end

  // power_control; mode bits self-clear when the mode is left
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_control_reg <= pmic_pkg::POWER_CONTROL_RESET;
    end else if (wr_pc) begin
      power_control_reg <= sfr_req_i.wdata & pmic_pkg::POWER_CONTROL_WMASK;
      if (state_next == pmic_pkg::PMIC_RUN) begin
        power_control_reg[pmic_pkg::PC_POWER_DOWN] <= 1'b0;
        power_control_reg[pmic_pkg::PC_DOZE_REQUEST] <= 1'b0;
      end
    end else if (state_reg != pmic_pkg::PMIC_RUN && state_next == pmic_pkg::PMIC_RUN) begin
      power_control_reg[pmic_pkg::PC_POWER_DOWN] <= 1'b0;
      power_control_reg[pmic_pkg::PC_DOZE_REQUEST] <= 1'b0;
    end
  end

  // port_io_control; a fault event beats a software clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_io_control_reg <= pmic_pkg::PORT_IO_CONTROL_RESET;
    end else begin
      if (wr_io) begin
        port_io_control_reg <= sfr_req_i.wdata;
      end
      if (fault_evt) begin
        port_io_control_reg[pmic_pkg::IO_SERIAL_FAULT] <= 1'b1;
      end else if (wr_io) begin
        // writing one leaves the flag as it was; only zero clears it
        port_io_control_reg[pmic_pkg::IO_SERIAL_FAULT] <=
          port_io_control_reg[pmic_pkg::IO_SERIAL_FAULT] &
          sfr_req_i.wdata[pmic_pkg::IO_SERIAL_FAULT];
      end
    end
  end

  // port drive modes registered so pads see glitch-free selects
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_one_reg <= pmic_pkg::PMIC_DRIVE_NORMAL;
      drive_two_reg <= pmic_pkg::PMIC_DRIVE_NORMAL;
      drive_three_reg <= pmic_pkg::PMIC_DRIVE_NORMAL;
    end else begin
      drive_one_reg <= port_mode(port_io_control_reg[pmic_pkg::IO_PORT_ONE_FLOAT],
        port_io_control_reg[pmic_pkg::IO_HIGH_Z_SELECT],
        port_io_control_reg[pmic_pkg::IO_FLOAT_IN_SHUTDOWN] && in_power_down);
      drive_two_reg <= port_mode(port_io_control_reg[pmic_pkg::IO_PORT_TWO_FLOAT],
        port_io_control_reg[pmic_pkg::IO_HIGH_Z_SELECT],
        port_io_control_reg[pmic_pkg::IO_FLOAT_IN_SHUTDOWN] && in_power_down);
      drive_three_reg <= port_mode(port_io_control_reg[pmic_pkg::IO_PORT_THREE_FLOAT],
        port_io_control_reg[pmic_pkg::IO_HIGH_Z_SELECT],
        port_io_control_reg[pmic_pkg::IO_FLOAT_IN_SHUTDOWN] && in_power_down);
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_req_i.rd && sfr_req_i.addr == pmic_pkg::ADDR_POWER_CONTROL) begin
      sfr_rdata_o <= power_control_reg;
    end else if (sfr_req_i.rd && sfr_req_i.addr == pmic_pkg::ADDR_PORT_IO_CONTROL) begin
      sfr_rdata_o <= port_io_control_reg;
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  assign sfr_hit_o = (sfr_req_i.rd || sfr_req_i.wr) &&
                     (sfr_req_i.addr == pmic_pkg::ADDR_POWER_CONTROL ||
                      sfr_req_i.addr == pmic_pkg::ADDR_PORT_IO_CONTROL);

  // idle keeps timers and uart clocked; power-down stops everything
  assign cpu_clk_stop_o = (state_reg != pmic_pkg::PMIC_RUN) || pin_down_reg;
  assign periph_clk_stop_o = in_power_down;
  assign osc_stop_o = in_power_down;
  assign port_one_drive_o = drive_one_reg;
  assign port_two_drive_o = drive_two_reg;
  assign port_three_drive_o = drive_three_reg;
  assign watchdog_bit_o = port_io_control_reg[pmic_pkg::IO_WATCHDOG];
  assign timer_width_bit_o = port_io_control_reg[pmic_pkg::IO_TIMER_WIDTH];
  assign baud_doubler_o = power_control_reg[pmic_pkg::PC_BAUD_DOUBLER];

  // checks
  chk_fault_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    fault_evt |=> port_io_control_reg[pmic_pkg::IO_SERIAL_FAULT])
    else $error("fault flag not set after receiver error");

  chk_fault_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (wr_io && !sfr_req_i.wdata[pmic_pkg::IO_SERIAL_FAULT] && !fault_evt)
    |=> !port_io_control_reg[pmic_pkg::IO_SERIAL_FAULT])
    else $error("fault flag not cleared by zero write");

  chk_sw_enter: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_reg == pmic_pkg::PMIC_RUN && wr_pc && sfr_req_i.wdata[pmic_pkg::PC_POWER_DOWN]
     && !sfr_req_i.wdata[pmic_pkg::PC_WAKE_POLICY])
    |=> state_reg == pmic_pkg::PMIC_SW_DOWN)
    else $error("software power-down not entered");

  chk_cancel_now: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_reg == pmic_pkg::PMIC_RUN && wr_pc && sfr_req_i.wdata[pmic_pkg::PC_POWER_DOWN]
     && sfr_req_i.wdata[pmic_pkg::PC_WAKE_POLICY] && irq_pending_i)
    |=> state_reg == pmic_pkg::PMIC_RUN && !osc_stop_o)
    else $error("power-down not cancelled with pending request");

  chk_gated_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_reg == pmic_pkg::PMIC_SW_DOWN && !power_control_reg[pmic_pkg::PC_WAKE_POLICY]
     && !ext_wake) |=> state_reg == pmic_pkg::PMIC_SW_DOWN)
    else $error("power-down left without enabled external interrupt");

  chk_policy_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_reg == pmic_pkg::PMIC_SW_DOWN && power_control_reg[pmic_pkg::PC_WAKE_POLICY]
     && irq_pending_i) |=> state_reg == pmic_pkg::PMIC_RUN)
    else $error("wake policy did not end power-down");

  chk_pin_down: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (pin_fall && !pin_down_reg && power_control_reg[pmic_pkg::PC_PIN_SHUTDOWN_ENABLE])
    |=> pin_down_reg && osc_stop_o)
    else $error("pin falling edge did not enter power-down");

  chk_pin_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (pin_down_reg && pin_rise) |=> !pin_down_reg)
    else $error("pin rising edge did not end power-down");

  chk_shut_float: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (in_power_down && port_io_control_reg[pmic_pkg::IO_FLOAT_IN_SHUTDOWN])
    |=> port_three_drive_o == pmic_pkg::PMIC_DRIVE_FLOAT)
    else $error("ports not floating in power-down");

  chk_high_z: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (port_io_control_reg[pmic_pkg::IO_HIGH_Z_SELECT] && !in_power_down &&
     !port_io_control_reg[pmic_pkg::IO_PORT_ONE_FLOAT])
    |=> port_one_drive_o == pmic_pkg::PMIC_DRIVE_HIGH_Z)
    else $error("port one not high impedance");

  chk_float_port: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_io_control_reg[pmic_pkg::IO_PORT_TWO_FLOAT]
    |=> port_two_drive_o == pmic_pkg::PMIC_DRIVE_FLOAT)
    else $error("port two not floating");

  chk_normal_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!port_io_control_reg[pmic_pkg::IO_HIGH_Z_SELECT] &&
     !port_io_control_reg[pmic_pkg::IO_PORT_ONE_FLOAT] &&
     !(port_io_control_reg[pmic_pkg::IO_FLOAT_IN_SHUTDOWN] && in_power_down))
    |=> port_one_drive_o == pmic_pkg::PMIC_DRIVE_NORMAL)
    else $error("port one not at normal impedance");

  chk_idle_enter: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_reg == pmic_pkg::PMIC_RUN && wr_pc && sfr_req_i.wdata[pmic_pkg::PC_DOZE_REQUEST]
     && !sfr_req_i.wdata[pmic_pkg::PC_POWER_DOWN] && !irq_pending_i)
    |=> state_reg == pmic_pkg::PMIC_IDLE)
    else $error("idle not entered");

  // timers and uart must keep their clock in idle
  chk_idle_clocks: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_reg == pmic_pkg::PMIC_IDLE && !pin_down_reg)
    |-> cpu_clk_stop_o && !periph_clk_stop_o && !osc_stop_o)
    else $error("idle clock gating wrong");

  chk_idle_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_reg == pmic_pkg::PMIC_IDLE && irq_pending_i) |=> state_reg == pmic_pkg::PMIC_RUN)
    else $error("idle not ended by interrupt request");

  chk_ext_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_reg == pmic_pkg::PMIC_SW_DOWN && ext_wake) |=> state_reg == pmic_pkg::PMIC_RUN)
    else $error("enabled external interrupt did not end power-down");

  chk_pin_apart: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (pin_fall && state_reg == pmic_pkg::PMIC_RUN && !wr_pc)
    |=> state_reg == pmic_pkg::PMIC_RUN && !power_control_reg[pmic_pkg::PC_POWER_DOWN])
    else $error("pin edge disturbed the software power-down path");

  chk_overrun_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (rx_char_done_i && rx_buf_unread_i) |=> port_io_control_reg[pmic_pkg::IO_SERIAL_FAULT])
    else $error("overwrite of unread character not flagged");

  chk_frame_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (rx_char_done_i && !rx_stop_bit_i) |=> port_io_control_reg[pmic_pkg::IO_SERIAL_FAULT])
    else $error("missing stop bit not flagged");

  chk_pc_gap: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_pc |=> (power_control_reg & ~pmic_pkg::POWER_CONTROL_WMASK) == 8'h00)
    else $error("unused power_control bit took a write");

  cov_idle_wake: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    state_reg == pmic_pkg::PMIC_IDLE ##1 state_reg == pmic_pkg::PMIC_RUN);
  cov_sw_wake: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    state_reg == pmic_pkg::PMIC_SW_DOWN ##1 state_reg == pmic_pkg::PMIC_RUN);
  cov_pin_cycle: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    pin_down_reg ##1 !pin_down_reg);
  cov_fault: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    fault_evt && wr_io);

endmodule

`default_nettype wire

// ==== common/pmic_pkg.sv ====
package pmic_pkg;

  // special-function addresses
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_PORT_IO_CONTROL = 8'hf8;

  // power_control bit positions
  localparam int PC_BAUD_DOUBLER = 7;
  localparam int PC_PIN_SHUTDOWN_ENABLE = 6;
  localparam int PC_WAKE_POLICY = 5;
  localparam int PC_GENERAL_FLAG_ONE = 3;
  localparam int PC_GENERAL_FLAG_ZERO = 2;
  localparam int PC_POWER_DOWN = 1;
  localparam int PC_DOZE_REQUEST = 0;

  // port_io_control bit positions
  localparam int IO_WATCHDOG = 7;
  localparam int IO_TIMER_WIDTH = 6;
  localparam int IO_SERIAL_FAULT = 5;
  localparam int IO_HIGH_Z_SELECT = 4;
  localparam int IO_PORT_THREE_FLOAT = 3;
  localparam int IO_PORT_TWO_FLOAT = 2;
  localparam int IO_PORT_ONE_FLOAT = 1;
  localparam int IO_FLOAT_IN_SHUTDOWN = 0;

  // reset values; bit 4 of power_control is unused and reads zero
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_IO_CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_CONTROL_WMASK = 8'hef;

  // per-port drive mode
  typedef enum logic [1:0] {
    PMIC_DRIVE_NORMAL = 2'h0,
    PMIC_DRIVE_HIGH_Z = 2'h1,
    PMIC_DRIVE_FLOAT = 2'h2
  } pmic_drive_t;

  // operating states, one-hot
  typedef enum logic [3:0] {
    PMIC_RUN = 4'h1,
    PMIC_IDLE = 4'h2,
    PMIC_SW_DOWN = 4'h4,
    PMIC_HW_DOWN = 4'h8
  } pmic_state_t;

  // register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmic_sfr_req_t;

  // serial receiver error events
  typedef struct packed {
    logic overrun;
    logic framing;
  } pmic_rx_err_t;

endpackage

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end

module tb;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  pmic_pkg::pmic_sfr_req_t req = '0;
  pmic_pkg::pmic_rx_err_t rx_err = '0;
  logic irq0 = 1'b0, irq1 = 1'b0, en0 = 1'b0, en1 = 1'b0, pend = 1'b0, pin = 1'b1;
  logic char_done = 1'b0, stop_bit = 1'b1, unread = 1'b0;
  logic [7:0] rdata;
  logic hit, cpu_stop, periph_stop, osc_stop, wdog, twidth, baud2;
  logic [1:0] d1, d2, d3;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  pmic_power_ctl DUT (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .sfr_hit_o(hit), .ext_irq_zero_i(irq0), .ext_irq_one_i(irq1),
    .ext_irq_zero_enable_i(en0), .ext_irq_one_enable_i(en1), .irq_pending_i(pend),
    .counter1_input_pin_i(pin), .rx_err_i(rx_err), .rx_char_done_i(char_done),
    .rx_stop_bit_i(stop_bit), .rx_buf_unread_i(unread), .cpu_clk_stop_o(cpu_stop),
    .periph_clk_stop_o(periph_stop), .osc_stop_o(osc_stop), .port_one_drive_o(d1),
    .port_two_drive_o(d2), .port_three_drive_o(d3), .watchdog_bit_o(wdog),
    .timer_width_bit_o(twidth), .baud_doubler_o(baud2)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  // generous ceiling: the whole sequence needs about 130 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    #1 req.wr = 1'b0;
  endtask

  // read data stands only one cycle after the strobe, so it is sampled right away
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    #1 `CHK(hit, (a == 8'h87 || a == 8'hf8))
    @(posedge clk_sys_i);
    #1 req.rd = 1'b0;
    `CHK(rdata, exp)
  endtask

  task automatic chk_drv(input logic [5:0] exp);
    `CHK({d3, d2, d1}, exp)
  endtask

  task automatic err_pulse(input int k);
    @(posedge clk_sys_i);
    #1;
    case (k)
      0: rx_err.overrun = 1'b1;
      1: rx_err.framing = 1'b1;
      2: begin char_done = 1'b1; unread = 1'b1; end
      default: begin char_done = 1'b1; stop_bit = 1'b0; end
    endcase
    @(posedge clk_sys_i);
    #1 rx_err = '0;
    char_done = 1'b0;
    unread = 1'b0;
    stop_bit = 1'b1;
  endtask

  task automatic complete_run();
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    rd(8'h87, 8'h00);
    rd(8'hf8, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hf8, 8'hc0);
    rd(8'hf8, 8'hc0);
    `CHK({wdog, twidth}, 2'h3)
    wr(8'hf8, 8'h10);
    tick(1);
    chk_drv(6'h15);
    wr(8'hf8, 8'h14);
    tick(1);
    chk_drv(6'h19);
    wr(8'hf8, 8'h01);
    tick(1);
    chk_drv(6'h00);
    for (int i = 0; i < 2; i++) begin
      wr(8'h87, 8'h02);
      `CHK({osc_stop, cpu_stop, periph_stop}, 3'h7)
      tick(1);
      chk_drv(6'h2a);
      if (i == 0) irq0 = 1'b1;
      else irq1 = 1'b1;
      tick(3);
      `CHK(osc_stop, 1'b1)
      if (i == 0) en0 = 1'b1;
      else en1 = 1'b1;
      tick(2);
      `CHK(osc_stop, 1'b0)
      {irq0, irq1, en0, en1} = 4'h0;
      rd(8'h87, 8'h00);
      chk_drv(6'h00);
    end
    // policy one: pending request wakes although external enables are off
    wr(8'h87, 8'h22);
    `CHK(osc_stop, 1'b1)
    pend = 1'b1;
    tick(2);
    `CHK(osc_stop, 1'b0)
    wr(8'h87, 8'h22);
    `CHK(osc_stop, 1'b0)
    pend = 1'b0;
    wr(8'h87, 8'h01);
    `CHK({cpu_stop, periph_stop, osc_stop}, 3'h4)
    pend = 1'b1;
    tick(2);
    `CHK(cpu_stop, 1'b0)
    // a request already pending keeps idle from taking hold
    wr(8'h87, 8'h01);
    `CHK(cpu_stop, 1'b0)
    rd(8'h87, 8'h00);
    pend = 1'b0;
    wr(8'h87, 8'h40);
    pin = 1'b0;
    tick(3);
    `CHK({osc_stop, periph_stop}, 2'h3)
    rd(8'h87, 8'h40);
    pin = 1'b1;
    tick(3);
    `CHK(osc_stop, 1'b0)
    // bit 4 is not implemented and must read back as zero
    wr(8'h87, 8'hfc);
    rd(8'h87, 8'hec);
    `CHK(baud2, 1'b1)
    wr(8'h87, 8'h00);
    for (int k = 0; k < 4; k++) begin
      err_pulse(k);
      rd(8'hf8, 8'h21);
      wr(8'hf8, 8'h01);
      rd(8'hf8, 8'h01);
    end
    wr(8'hf8, 8'h21);
    rd(8'hf8, 8'h01);
    // hardware reset must pull the block out of either low-power mode
    wr(8'h87, 8'h02);
    tick(1);
    chk_drv(6'h2a);
    rst_b_i = 1'b0;
    #1 `CHK({cpu_stop, periph_stop, osc_stop, d3, d2, d1}, 9'h000)
    tick(2);
    rst_b_i = 1'b1;
    rd(8'h87, 8'h00);
    rd(8'hf8, 8'h00);
    wr(8'h87, 8'h01);
    `CHK(cpu_stop, 1'b1)
    rst_b_i = 1'b0;
    #1 `CHK(cpu_stop, 1'b0)
    tick(1);
    rst_b_i = 1'b1;
    rd(8'h87, 8'h00);
    complete_run();
  end
endmodule

`default_nettype wire
